// >>> include/dhp_pkg.sv
package dhp_pkg;

    // =====================================================================
    // timing
    // =====================================================================
    localparam int CLK_PERIOD_NS  = 4;
    localparam int CLK_MHZ        = 250;
    localparam int STEP_PULSE_NS  = 1000;
    localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_UNIT_US   = 1000;
    localparam int STEP_UNIT_CYC  = STEP_UNIT_US * CLK_MHZ;
    localparam int CNT_W          = 24;

    // =====================================================================
    // register map (byte addresses)
    // =====================================================================
    localparam logic [7:0] ADDR_CMD      = 8'h00;
    localparam logic [7:0] ADDR_TARGET   = 8'h04;
    localparam logic [7:0] ADDR_STEP     = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_SENSE    = 8'h10;
    localparam logic [7:0] ADDR_ID       = 8'h14;
    localparam logic [7:0] ADDR_RP_STAT  = 8'h18;
    localparam int         CMD_DRV_LSB   = 4;
    localparam logic [3:0] STEP_RST      = 4'h0;
    localparam logic [6:0] RECAL_MAX     = 7'd79;
    localparam logic [1:0] IDX_LIMIT     = 2'd2;
    localparam int         NUM_DRV       = 4;

    // =====================================================================
    // codes and carriers
    // =====================================================================
    localparam logic [1:0] IC_NORMAL = 2'h0;
    localparam logic [1:0] IC_ABNORM = 2'h1;
    localparam logic [1:0] IC_INVAL  = 2'h2;
    localparam logic [1:0] IC_POLL   = 2'h3;

    typedef enum logic [3:0] {
        OP_NONE   = 4'h0,
        OP_RECAL  = 4'h1,
        OP_SEEK   = 4'h2,
        OP_RDPOS  = 4'h3,
        OP_SENSE  = 4'h4,
        OP_PWRDN  = 4'h5,
        OP_PWRUP  = 4'h6
    } dhp_op_t;

    typedef enum logic [1:0] {
        SK_IDLE  = 2'b00,
        SK_CHECK = 2'b01,
        SK_PULSE = 2'b10,
        SK_WAIT  = 2'b11
    } dhp_sk_state_t;

    typedef struct packed {
        logic [1:0] ic;
        logic       se;
        logic       ec;
        logic       nr;
        logic       hd;
        logic [1:0] ds;
    } dhp_st0_t;

    typedef struct packed {
        logic [1:0] ic;
        logic       se;
        logic       ec;
    } dhp_seek_res_t;

    typedef struct packed {
        logic [7:0] cyl;
        logic [7:0] head;
        logic [7:0] sec;
        logic [7:0] size;
    } dhp_id_t;

endpackage

// >>> rtl/dhp_ctrl.sv
// Implementation choices: the address-and-strobe port and the register addresses.
module dhp_ctrl #(
    parameter int STEP_UNIT = dhp_pkg::STEP_UNIT_CYC
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rstn,
    input  wire logic [7:0]            i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [31:0]                o_rdata,
    input  wire logic [3:0]            i_track_zero_input_n,
    input  wire logic                  i_index_pulse_input_n,
    input  wire logic                  i_id_valid,
    input  wire dhp_pkg::dhp_id_t      i_id_field,
    input  wire logic                  i_result_entry,
    input  wire logic                  i_nondma_req,
    output logic [3:0]                 o_step,
    output logic [3:0]                 o_dir,
    output logic                       o_int
);
    import dhp_pkg::*;

    // =====================================================================
    // pin synchronisers
    // =====================================================================
    // three stages per pin; a level is accepted once stage two and three agree
    logic [4:0]     pin_raw;
    logic [4:0]     sync1_reg;
    logic [4:0]     sync2_reg;
    logic [4:0]     sync3_reg;
    logic [4:0]     pin_reg;
    logic [3:0]     at_tz_w;
    logic           index_low_w;
    logic           index_prev_reg;
    logic           index_fall_w;

    assign pin_raw = {i_index_pulse_input_n, i_track_zero_input_n};

    genvar gp;
    generate
        for (gp = 0; gp < 5; gp++)
        begin : g_sync
            always_ff @(posedge i_sys_clk)
            begin
                if (!i_rstn)
                begin
                    sync1_reg[gp] <= 1'b1;
                    sync2_reg[gp] <= 1'b1;
                    sync3_reg[gp] <= 1'b1;
                    pin_reg[gp]   <= 1'b1;
                end
                else
                begin
                    sync1_reg[gp] <= pin_raw[gp];
                    sync2_reg[gp] <= sync1_reg[gp];
                    sync3_reg[gp] <= sync2_reg[gp];
                    if (sync2_reg[gp] == sync3_reg[gp])
                    begin
                        pin_reg[gp] <= sync3_reg[gp];
                    end
                end
            end
        end
    endgenerate

    // track zero line is high once the head sits on track zero
    assign at_tz_w      = pin_reg[3:0];
    assign index_low_w  = !pin_reg[4];
    assign index_fall_w = index_low_w && !index_prev_reg;

    // =====================================================================
    // register bus decode
    // =====================================================================
    logic           wr_cmd_w;
    logic           wr_tgt_w;
    logic           wr_step_w;
    dhp_op_t        op_w;
    logic [1:0]     drv_w;
    logic           lp_reg;
    logic           cmd_ok_w;
    logic           do_recal_w;
    logic           do_seek_w;
    logic           do_rdpos_w;
    logic           do_sense_w;
    logic           do_pwrdn_w;
    logic           do_pwrup_w;

    assign wr_cmd_w   = i_wr && (i_addr == ADDR_CMD);
    assign wr_tgt_w   = i_wr && (i_addr == ADDR_TARGET);
    assign wr_step_w  = i_wr && (i_addr == ADDR_STEP);
    assign op_w       = dhp_op_t'(i_wdata[3:0]);
    assign drv_w      = i_wdata[CMD_DRV_LSB +: 2];
    // only wake-up is heard while in low power
    assign cmd_ok_w   = wr_cmd_w && !lp_reg;
    assign do_recal_w = cmd_ok_w && (op_w == OP_RECAL);
    assign do_seek_w  = cmd_ok_w && (op_w == OP_SEEK);
    assign do_sense_w = cmd_ok_w && (op_w == OP_SENSE);
    assign do_pwrdn_w = cmd_ok_w && (op_w == OP_PWRDN);
    assign do_pwrup_w = wr_cmd_w && lp_reg && (op_w == OP_PWRUP);

    // =====================================================================
    // settings and command phase
    // =====================================================================
    logic [7:0]     target_reg;
    logic [3:0]     step_set_reg;
    logic [23:0]    interval_reg;
    logic           cmd_phase_reg;
    logic           clear_all_reg;
    logic           rp_active_reg;

    assign do_rdpos_w = cmd_ok_w && (op_w == OP_RDPOS) && !rp_active_reg;

    // interval is precomputed so the step timers only load a value
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            target_reg     <= '0;
            step_set_reg   <= STEP_RST;
            interval_reg   <= 24'(16 * STEP_UNIT);
            cmd_phase_reg  <= 1'b0;
            lp_reg         <= 1'b0;
            clear_all_reg  <= 1'b0;
            index_prev_reg <= 1'b0;
        end
        else
        begin
            if (wr_tgt_w)
            begin
                target_reg <= i_wdata[7:0];
            end
            if (wr_step_w)
            begin
                step_set_reg <= i_wdata[3:0];
            end
            interval_reg   <= 24'((16 - int'(step_set_reg)) * STEP_UNIT);
            cmd_phase_reg  <= do_recal_w || do_seek_w;
            lp_reg         <= do_pwrdn_w || (lp_reg && !do_pwrup_w);
            clear_all_reg  <= do_pwrup_w;
            index_prev_reg <= index_low_w;
        end
    end

    // =====================================================================
    // per drive positioning units
    // =====================================================================
    logic [3:0]     drv_busy_w;
    logic [3:0]     drv_pend_w;
    logic [3:0]     ack_w;
    dhp_seek_res_t  drv_res_w [NUM_DRV];
    logic [7:0]     drv_pcn_w [NUM_DRV];

    genvar gd;
    generate
        for (gd = 0; gd < NUM_DRV; gd++)
        begin : g_drv
            // other drives accept commands while one steps
            dhp_seek_unit u_seek (
                .i_sys_clk       (i_sys_clk),
                .i_rstn          (i_rstn),
                .i_clear         (clear_all_reg),
                .i_start         ((do_recal_w || do_seek_w) && (drv_w == 2'(gd))),
                .i_recal         (do_recal_w),
                .i_target        (target_reg),
                .i_interval      (interval_reg),
                .i_at_track_zero (at_tz_w[gd]),
                .i_ack           (ack_w[gd]),
                .o_step          (o_step[gd]),
                .o_dir           (o_dir[gd]),
                .o_busy          (drv_busy_w[gd]),
                .o_pending       (drv_pend_w[gd]),
                .o_res           (drv_res_w[gd]),
                .o_pcn           (drv_pcn_w[gd])
            );
        end
    endgenerate

    // =====================================================================
    // interrupt query selection
    // =====================================================================
    // lowest numbered pending drive is reported first
    logic [1:0]     sel_drv_w;
    logic           sel_any_w;
    logic           poll_reg;
    dhp_st0_t       sense_st0_w;

    always_comb
    begin
        sel_drv_w = 2'd0;
        sel_any_w = 1'b0;
        for (int k = NUM_DRV - 1; k >= 0; k--)
        begin
            if (drv_pend_w[k])
            begin
                sel_drv_w = 2'(k);
                sel_any_w = 1'b1;
            end
        end
    end

    assign ack_w = (do_sense_w && sel_any_w) ? (4'h1 << sel_drv_w) : 4'h0;

    assign sense_st0_w = sel_any_w ?
        '{ic: drv_res_w[sel_drv_w].ic, se: 1'b1, ec: drv_res_w[sel_drv_w].ec, nr: 1'b0, hd: 1'b0, ds: sel_drv_w} :
        poll_reg ? '{ic: IC_POLL, se: 1'b0, ec: 1'b0, nr: 1'b0, hd: 1'b0, ds: 2'd0} :
        '{ic: IC_INVAL, se: 1'b0, ec: 1'b0, nr: 1'b0, hd: 1'b0, ds: 2'd0};

    // =====================================================================
    // read position and stored status
    // =====================================================================
    logic [1:0]     idx_cnt_reg;
    dhp_id_t        id_reg;
    dhp_st0_t       rp_st0_reg;
    logic           rp_ma_reg;
    logic           rp_int_reg;
    logic           data_int_reg;
    dhp_st0_t       sense_reg;
    logic [7:0]     sense_pcn_reg;
    logic           rp_found_w;
    logic           rp_miss_w;

    assign rp_found_w = rp_active_reg && i_id_valid;
    assign rp_miss_w  = rp_active_reg && !i_id_valid && index_fall_w && (idx_cnt_reg == IDX_LIMIT - 2'd1);

    // sources set in the same cycle a query clears them survive the clear
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || clear_all_reg)
        begin
            rp_active_reg <= 1'b0;
            idx_cnt_reg   <= '0;
            id_reg        <= '0;
            rp_st0_reg    <= '0;
            rp_ma_reg     <= 1'b0;
            rp_int_reg    <= 1'b0;
            data_int_reg  <= 1'b0;
            sense_reg     <= '0;
            sense_pcn_reg <= '0;
            poll_reg      <= !clear_all_reg;
        end
        else
        begin
            if (do_rdpos_w)
            begin
                rp_active_reg <= 1'b1;
                idx_cnt_reg   <= '0;
                rp_ma_reg     <= 1'b0;
                rp_st0_reg    <= '{ic: IC_NORMAL, se: 1'b0, ec: 1'b0, nr: 1'b0, hd: 1'b0, ds: drv_w};
            end
            else if (rp_found_w)
            begin
                rp_active_reg <= 1'b0;
                id_reg        <= i_id_field;
                rp_st0_reg.hd <= i_id_field.head[0];
            end
            else if (rp_miss_w)
            begin
                rp_active_reg <= 1'b0;
                rp_st0_reg.ic <= IC_ABNORM;
                rp_ma_reg     <= 1'b1;
            end
            else if (rp_active_reg && index_fall_w)
            begin
                idx_cnt_reg <= idx_cnt_reg + 2'd1;
            end
            // only position command among control ones
            rp_int_reg   <= rp_found_w || rp_miss_w || (rp_int_reg && !do_sense_w);
            data_int_reg <= i_result_entry || (data_int_reg && !do_sense_w);
            poll_reg     <= poll_reg && !(do_sense_w && !sel_any_w);
            if (do_sense_w)
            begin
                sense_reg     <= sense_st0_w;
                sense_pcn_reg <= sel_any_w ? drv_pcn_w[sel_drv_w] : 8'h00;
            end
        end
    end

    // =====================================================================
    // interrupt line and read data
    // =====================================================================
    logic [31:0]    rd_mux_w;
    logic [31:0]    status_w;

    assign status_w = {25'h0, lp_reg, o_int, cmd_phase_reg || rp_active_reg, drv_busy_w};

    always_comb
    begin
        if (i_addr == ADDR_STATUS)
        begin
            rd_mux_w = status_w;
        end
        else if (i_addr == ADDR_SENSE)
        begin
            rd_mux_w = {16'h0, sense_pcn_reg, sense_reg};
        end
        else if (i_addr == ADDR_ID)
        begin
            rd_mux_w = id_reg;
        end
        else if (i_addr == ADDR_RP_STAT)
        begin
            rd_mux_w = {16'h0, 7'h0, rp_ma_reg, rp_st0_reg};
        end
        else if (i_addr == ADDR_TARGET)
        begin
            rd_mux_w = {24'h0, target_reg};
        end
        else if (i_addr == ADDR_STEP)
        begin
            rd_mux_w = {28'h0, step_set_reg};
        end
        else
        begin
            rd_mux_w = 32'h0;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            o_rdata <= '0;
            o_int   <= 1'b0;
        end
        else
        begin
            o_rdata <= i_rd ? rd_mux_w : 32'h0;
            o_int   <= (|drv_pend_w) || poll_reg || rp_int_reg || data_int_reg || i_nondma_req;
        end
    end

endmodule

// >>> rtl/dhp_seek_unit.sv
module dhp_seek_unit (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_clear,
    input  wire logic                  i_start,
    input  wire logic                  i_recal,
    input  wire logic [7:0]            i_target,
    input  wire logic [23:0]           i_interval,
    input  wire logic                  i_at_track_zero,
    input  wire logic                  i_ack,
    output logic                       o_step,
    output logic                       o_dir,
    output logic                       o_busy,
    output logic                       o_pending,
    output dhp_pkg::dhp_seek_res_t     o_res,
    output logic [7:0]                 o_pcn
);
    import dhp_pkg::*;

    dhp_sk_state_t  state_reg;
    logic [23:0]    cnt_reg;
    logic [6:0]     steps_reg;
    logic [7:0]     target_reg;
    logic           recal_reg;
    logic           done_w;
    logic           abn_w;
    logic           go_w;

    // =====================================================================
    // end of motion decision
    // =====================================================================
    // recalibrate: track zero or step limit reached; seek: cylinder equals target
    assign done_w = (state_reg == SK_CHECK) &&
                    (recal_reg ? (i_at_track_zero || steps_reg == RECAL_MAX) : (o_pcn == target_reg));
    assign abn_w  = recal_reg && !i_at_track_zero && (steps_reg == RECAL_MAX);
    assign go_w   = i_start && !o_busy;

    // motion sequencer; direction is registered one cycle before any pulse
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || i_clear)
        begin
            state_reg  <= SK_IDLE;
            cnt_reg    <= '0;
            steps_reg  <= '0;
            target_reg <= '0;
            recal_reg  <= 1'b0;
            o_step     <= 1'b0;
            o_dir      <= 1'b0;
            o_pcn      <= '0;
        end
        else
        begin
            case (state_reg)
                SK_IDLE:
                begin
                    if (go_w)
                    begin
                        recal_reg  <= i_recal;
                        target_reg <= i_target;
                        steps_reg  <= '0;
                        state_reg  <= SK_CHECK;
                        if (i_recal)
                        begin
                            o_pcn <= '0;
                            o_dir <= 1'b0;
                        end
                        else
                        begin
                            o_dir <= (o_pcn < i_target);
                        end
                    end
                end
                SK_CHECK:
                begin
                    if (done_w)
                    begin
                        state_reg <= SK_IDLE;
                    end
                    else
                    begin
                        o_step    <= 1'b1;
                        cnt_reg   <= 24'(STEP_PULSE_CYC - 1);
                        state_reg <= SK_PULSE;
                    end
                end
                SK_PULSE:
                begin
                    if (cnt_reg == '0)
                    begin
                        o_step    <= 1'b0;
                        steps_reg <= steps_reg + 7'd1;
                        if (!recal_reg)
                        begin
                            o_pcn <= o_dir ? o_pcn + 8'd1 : o_pcn - 8'd1;
                        end
                        cnt_reg   <= i_interval - 24'd1;
                        state_reg <= SK_WAIT;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - 24'd1;
                    end
                end
                default:
                begin
                    if (cnt_reg == '0)
                    begin
                        state_reg <= SK_CHECK;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - 24'd1;
                    end
                end
            endcase
        end
    end

    // completion flag and busy; a completion beats a same-cycle acknowledge
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || i_clear)
        begin
            o_pending <= 1'b0;
            o_busy    <= 1'b0;
            o_res     <= '0;
        end
        else
        begin
            o_pending <= done_w || (o_pending && !i_ack);
            o_busy    <= go_w || (o_busy && !(i_ack && o_pending && !done_w));
            if (done_w)
            begin
                o_res <= '{ic: abn_w ? IC_ABNORM : IC_NORMAL, se: 1'b1, ec: abn_w};
            end
        end
    end

endmodule

// >>> sim/dhp_ctrl_props.sv
// ====
// checker on the controller pins
module dhp_ctrl_props
    import dhp_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rstn,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_result_entry,
    input wire logic        i_nondma_req,
    input wire logic [3:0]  o_step,
    input wire logic [3:0]  o_dir,
    input wire logic        o_int
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // recalibrate of drive 0 taken on the bus
    sequence s_recal0;
        i_wr && i_addr == ADDR_CMD && i_wdata[5:0] == 6'h01;
    endsequence
    sequence s_step_rise;
        $rose(o_step[0]);
    endsequence
    a_dir_settled: assert property (s_step_rise |-> $stable(o_dir[0]))
        else $error("direction moved with step edge");
    a_step_width: assert property (s_step_rise |-> o_step[0] [*8])
        else $error("step pulse too short");
    // gap is at least interval plus one, five cycles with the bench setting; four are checked
    a_step_gap: assert property ($fell(o_step[0]) |-> !o_step[0] [*4])
        else $error("step pulses too close");
    a_recal_outward: assert property (s_recal0 |-> ##2 !o_dir[0])
        else $error("recalibrate not stepping outward");
    a_nondma_raise: assert property (i_nondma_req |=> o_int)
        else $error("no interrupt for transfer need");
    a_result_raise: assert property (i_result_entry |-> ##[1:2] o_int)
        else $error("no interrupt on result entry");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside read slot");
    a_reset_quiet: assert property (disable iff (1'b0) !i_rstn |=> o_step == 4'h0 && !o_int)
        else $error("outputs active in reset");
endmodule
bind dhp_ctrl dhp_ctrl_props u_props (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_result_entry(i_result_entry),
    .i_nondma_req(i_nondma_req), .o_step(o_step), .o_dir(o_dir), .o_int(o_int));

// >>> sim/dhp_ctrl_tb_top.sv
module dhp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dhp_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, idx_n = 1, idv = 0, res = 0, ndma = 0, irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [3:0] stp, dir, tz_n, stuck = 4'h0, stp_q = 4'h0;
    dhp_id_t idf = 32'h0a010203;
    int n_fail = 0, cmp_count = 0, cyc = 0, n_step [4] = '{default: 0};
    dhp_ctrl #(.STEP_UNIT(4)) dut (.i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .i_track_zero_input_n(tz_n), .i_index_pulse_input_n(idx_n), .i_id_valid(idv),
        .i_id_field(idf), .i_result_entry(res), .i_nondma_req(ndma), .o_step(stp), .o_dir(dir), .o_int(irq));
    dhp_drive_model u_drv (.i_sys_clk(clk), .i_step(stp), .i_dir(dir), .i_stuck(stuck), .o_track_zero_n(tz_n));
    // ====
    // clock, step counting and hang guard
    initial
        forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        stp_q <= stp;
        for (int i = 0; i < 4; i++)
            if (stp[i] && !stp_q[i])
                n_step[i]++;
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            complete_run;
        end
    end
    // ====
    // bus tasks
    task bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task bus_rd(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        // taken at the closing edge of the data slot, so the next request starts on an edge
        @(posedge clk);
        d = rdat;
    endtask
    task sense;
        bus_wr(ADDR_CMD, 32'h4);
        bus_rd(ADDR_SENSE);
    endtask
    task wait_int;
        while (irq !== 1'b1)
            @(posedge clk);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task seek(input logic [31:0] cmd, input logic [7:0] tgt);
        bus_wr(ADDR_TARGET, {24'h0, tgt});
        bus_wr(ADDR_CMD, cmd);
        wait_int;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ====
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        bus_wr(ADDR_STEP, 32'hf);
        wait_int;
        sense;
        chk("poll", 16'h00c0, d[15:0]);
        bus_wr(ADDR_TARGET, 32'h3);
        bus_wr(ADDR_CMD, 32'h2);
        repeat (4) @(posedge clk);
        bus_rd(ADDR_STATUS);
        chk("exec_busy", 2'b01, {d[4], d[0]});
        wait_int;
        chk("dir_in", 1'b1, dir[0]);
        chk("steps_in", 3, n_step[0]);
        sense;
        chk("seek_st", 16'h0320, d[15:0]);
        chk("int_clr", 1'b0, irq);
        bus_rd(ADDR_STATUS);
        chk("unbusy", 1'b0, d[0]);
        seek(32'h2, 8'h1);
        chk("dir_out", 1'b0, dir[0]);
        chk("steps_out", 5, n_step[0]);
        sense;
        chk("seek_back", 16'h0120, d[15:0]);
        seek(32'h1, 8'h0);
        sense;
        chk("recal", 16'h0020, d[15:0]);
        chk("recal_steps", 6, n_step[0]);
        stuck <= 4'h2;
        seek(32'h11, 8'h0);
        sense;
        chk("recal_fail", 16'h0071, d[15:0]);
        chk("recal_limit", 79, n_step[1]);
        bus_wr(ADDR_CMD, 32'h3);
        repeat (2)
        begin
            idx_n <= 1'b0;
            repeat (6) @(posedge clk);
            idx_n <= 1'b1;
            repeat (6) @(posedge clk);
        end
        wait_int;
        bus_rd(ADDR_RP_STAT);
        chk("no_mark", 3'b101, {d[8], d[7:6]});
        sense;
        bus_wr(ADDR_CMD, 32'h3);
        idv <= 1'b1;
        @(posedge clk);
        idv <= 1'b0;
        wait_int;
        bus_rd(ADDR_ID);
        chk("id_field", 32'h0a010203, d);
        sense;
        res <= 1'b1;
        @(posedge clk);
        res <= 1'b0;
        wait_int;
        sense;
        chk("res_clr", 1'b0, irq);
        seek(32'h2, 8'h2);
        sense;
        bus_wr(ADDR_CMD, 32'h5);
        bus_rd(ADDR_STATUS);
        chk("low_power", 1'b1, d[6]);
        bus_wr(ADDR_CMD, 32'h6);
        bus_rd(ADDR_RP_STAT);
        chk("wake_stat", 9'h0, d[8:0]);
        seek(32'h2, 8'h1);
        chk("wake_pcn", 1'b1, dir[0]);
        sense;
        seek(32'h1, 8'h0);
        sense;
        chk("recal_back", 16'h0020, d[15:0]);
        ndma <= 1'b1;
        @(posedge clk);
        ndma <= 1'b0;
        @(posedge clk);
        chk("ndma_int", 1'b1, irq);
        repeat (3) @(posedge clk);
        complete_run;
    end
endmodule

// >>> sim/dhp_drive_model.sv
// ====
// four head mechanisms, one track per step edge
module dhp_drive_model (
    input  wire logic       i_sys_clk,
    input  wire logic [3:0] i_step,
    input  wire logic [3:0] i_dir,
    input  wire logic [3:0] i_stuck,
    output logic [3:0]      o_track_zero_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pos [4] = '{default: 8'h0};
    logic [3:0] step_q = 4'h0;
    // head moves on the rising step edge only
    always @(posedge i_sys_clk)
    begin
        step_q <= i_step;
        for (int i = 0; i < 4; i++)
            if (i_step[i] && !step_q[i])
                pos[i] <= i_dir[i] ? pos[i] + 8'h1 : pos[i] - 8'h1;
    end
    // a stuck sensor never reports the outer stop, to force the step limit
    always_comb
        for (int i = 0; i < 4; i++)
            o_track_zero_n[i] = (pos[i] == 8'h0) && !i_stuck[i];
endmodule
